// ### pkg/pdab_pkg.sv
// Purpose: Shared constants for the PWM dead-time, alignment and break stage.
// Assumes: 8-bit special function register port with a page number.
// Notes: Offsets are the register addresses; page codes qualify shared ones.
package pdab_pkg;
  // ==========================================================================
  // Register addresses and pages
  localparam logic [7:0] PDAB_ADDR_AUX_BREAK = 8'ha1;
  localparam logic [7:0] PDAB_ADDR_AUX_FIFO_CLK = 8'ha4;
  localparam logic [3:0] PDAB_PAGE_AUX_FIFO_CLK = 4'h6;
  localparam logic [7:0] PDAB_ADDR_DEAD_TIME = 8'hbc;
  localparam logic [3:0] PDAB_PAGE_DEAD_TIME = 4'h1;
  localparam logic [7:0] PDAB_ADDR_PWM_CTRL = 8'hbc;
  localparam logic [3:0] PDAB_PAGE_PWM_CTRL = 4'h0;
  localparam logic [7:0] PDAB_ADDR_MODE_BASE = 8'hda;
  localparam logic [3:0] PDAB_PAGE_MODE_LOW = 4'h0;
  localparam int PDAB_NUM_CH = 6;
  localparam int PDAB_MODE_PAGED = 2;

  // ==========================================================================
  // Field positions
  localparam int PDAB_BIT_BREAK_FLAG = 4;
  localparam int PDAB_LSB_FIFO_SEL = 2;
  localparam int PDAB_LSB_DT_PRESCALE = 6;
  localparam int PDAB_BIT_CENTER = 7;
  localparam int PDAB_BIT_EXTEND = 6;
  localparam int PDAB_BIT_BREAK_MODE = 5;
  localparam int PDAB_LSB_SRC1 = 3;
  localparam int PDAB_LSB_SRC0 = 0;
  localparam int PDAB_BIT_DT_EN = 7;
  localparam int PDAB_BIT_CMP_EN = 6;
  localparam int PDAB_BIT_PWM_EN = 1;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] PDAB_RST_REG = 8'h00;
  localparam logic [5:0] PDAB_DT_DISABLED = 6'h00;

  // ==========================================================================
  // Source selections
  typedef enum logic [1:0] {
    PDAB_S1_OFF = 2'b00,
    PDAB_S1_IRQ2 = 2'b01,
    PDAB_S1_RSVD = 2'b10,
    PDAB_S1_KBD = 2'b11
  } pdab_src1_t;

  localparam logic [2:0] PDAB_S0_IRQ1 = 3'b010;
  localparam logic [2:0] PDAB_S0_T2EX = 3'b011;
  localparam logic [2:0] PDAB_S0_KBD = 3'b100;

  typedef enum logic [1:0] {
    PDAB_FU_T0 = 2'b00,
    PDAB_FU_T1 = 2'b01,
    PDAB_FU_T3 = 2'b10,
    PDAB_FU_S0 = 2'b11
  } pdab_fifo_sel_t;

  localparam logic [1:0] PDAB_BREAK_LATCHED = 2'b00;
  localparam int PDAB_HOLD_W = 10;
endpackage

// ### rtl/pdab_dead_time.sv
// Purpose: Dead-time insertion for one complementary output pair.
// Assumes: dt_tick is a one-cycle pulse of the prescaled dead-time clock.
// Notes: A pulse shorter than the dead time leaves both outputs low.
`timescale 1ns/1ps
module pdab_dead_time #(
  parameter int DT_W = 6
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic dt_tick,
  input wire logic [DT_W-1:0] dt_count,
  input wire logic dt_active,
  // Waveform
  input wire logic pwm_in,
  output logic out_high,
  output logic out_low
);
  logic level_q;
  logic [DT_W-1:0] cnt_q;

  // ==========================================================================
  // Edge tracking: both sides drop, the new side rises after the count
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      level_q <= 1'b0;
      cnt_q <= '0;
      out_high <= 1'b0;
      out_low <= 1'b0;
    end else if (!dt_active) begin
      level_q <= pwm_in;
      cnt_q <= '0;
      out_high <= pwm_in;
      out_low <= ~pwm_in;
    end else if (pwm_in != level_q) begin
      level_q <= pwm_in;
      cnt_q <= dt_count;
      out_high <= 1'b0;
      out_low <= 1'b0;
    end else if (cnt_q != '0) begin
      if (dt_tick) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end else begin
      out_high <= level_q;
      out_low <= ~level_q;
    end
  end
endmodule

// ### rtl/pdab_top.sv
// Purpose: Dead time, edge or centre alignment and break for PWM channels 0-5.
// Assumes: Raw PWM levels and cycle starts come from the shared compare engine.
// Notes: Register reads return one cycle after the address is presented.
`timescale 1ns/1ps

// Operation
// - Dead time works only on modules 0, 2 and 4 and only while their pair is buffered.
// - The dead-time counter runs on the system clock divided by 1, 2, 4 or 8.
// - A dead-time value of zero disables it, any other value inserts that many ticks.
// - Centre alignment, when enabled, runs channels 0-5 at half the edge-aligned rate.
// - Centre alignment supports only the 8, 10, 12 and 16-bit counter resolutions.
// - The extend bit lengthens each PWM period by twice the dead time.
// - Break mode bit 0 gives latched break, 1 gives cycle-by-cycle break.
// - Break source 1 picks off, external interrupt 2, reserved or keyboard match.
// - Break source 0 picks off, external interrupt 1, timer 2 input or keyboard match.
// - A firing break source sets the flag and blocks channels 0-5 back to port I/O.
// - Only software clears the flag, and software writing one triggers a break.
// - Bits 3 to 2 of the auxiliary register choose the FIFO data update clock.
// - All channels share one counter resolution and cycle start and run together.
// - Update clock codes pick timer 0, timer 1, timer 3 or serial timer overflow.
// - Pair enables join modules 0-1, 2-3 and 4-5 into buffered pairs.
module pdab_top
  import pdab_pkg::*;
#(
  parameter int NUM_CH = 6
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Special function register port
  input wire logic [7:0] sfr_addr,
  input wire logic [3:0] sfr_page,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Compare engine side
  input wire logic [NUM_CH-1:0] pwm_raw,
  input wire logic pwm_cycle_start,
  input wire logic [2:0] pair_buffer_enable,
  input wire logic [1:0] counter_resolution,
  // Break event inputs
  input wire logic ext_irq1_event,
  input wire logic ext_irq2_event,
  input wire logic timer2_external_input,
  input wire logic keyboard_match_event,
  // Update clock sources
  input wire logic timer0_overflow,
  input wire logic timer1_overflow,
  input wire logic timer3_overflow,
  input wire logic serial0_timer_overflow,
  // Outputs to pins and counter
  output logic [NUM_CH-1:0] complementary_high,
  output logic [NUM_CH-1:0] complementary_low,
  output logic [NUM_CH-1:0] channel_pin_pwm_sel,
  output logic fifo_update_clock,
  output logic count_down,
  output logic counter_hold,
  output logic break_flag
);
  import pdab_pkg::*;

  // ==========================================================================
  // Registers
  logic break_flag_q;
  logic [1:0] fifo_sel_q;
  logic [7:0] dead_time_q;
  logic [7:0] pwm_ctrl_q;
  logic [7:0] mode_q [NUM_CH];
  logic [2:0] presc_q;
  logic cbc_block_q;
  logic dir_q;
  logic [PDAB_HOLD_W-1:0] hold_q;
  logic fifo_clk_q;
  logic [7:0] rdata_q;

  // ==========================================================================
  // Address decode
  wire hit_break = sfr_addr == PDAB_ADDR_AUX_BREAK;
  wire hit_fifo = sfr_addr == PDAB_ADDR_AUX_FIFO_CLK && sfr_page == PDAB_PAGE_AUX_FIFO_CLK;
  wire hit_dt = sfr_addr == PDAB_ADDR_DEAD_TIME && sfr_page == PDAB_PAGE_DEAD_TIME;
  wire hit_ctrl = sfr_addr == PDAB_ADDR_PWM_CTRL && sfr_page == PDAB_PAGE_PWM_CTRL;
  wire [7:0] mode_idx = sfr_addr - PDAB_ADDR_MODE_BASE;
  wire mode_in_range = sfr_addr >= PDAB_ADDR_MODE_BASE && mode_idx < 8'(NUM_CH);
  wire mode_page_ok = mode_idx >= 8'(PDAB_MODE_PAGED) || sfr_page == PDAB_PAGE_MODE_LOW;
  wire hit_mode = mode_in_range && mode_page_ok;

  // ==========================================================================
  // Control fields
  wire [1:0] dt_prescale = dead_time_q[PDAB_LSB_DT_PRESCALE +: 2];
  wire [5:0] dt_count = dead_time_q[5:0];
  wire dt_on = dt_count != PDAB_DT_DISABLED;
  wire center_align_enable = pwm_ctrl_q[PDAB_BIT_CENTER];
  wire extend_period = pwm_ctrl_q[PDAB_BIT_EXTEND];
  wire break_mode_select = pwm_ctrl_q[PDAB_BIT_BREAK_MODE];
  wire [1:0] src1_sel = pwm_ctrl_q[PDAB_LSB_SRC1 +: 2];
  wire [2:0] src0_sel = pwm_ctrl_q[PDAB_LSB_SRC0 +: 3];

  // ==========================================================================
  // Break sources; reserved codes never fire
  wire src1_fire = (src1_sel == PDAB_S1_IRQ2 && ext_irq2_event)
    || (src1_sel == PDAB_S1_KBD && keyboard_match_event);
  wire src0_fire = (src0_sel == PDAB_S0_IRQ1 && ext_irq1_event)
    || (src0_sel == PDAB_S0_T2EX && timer2_external_input)
    || (src0_sel == PDAB_S0_KBD && keyboard_match_event);
  wire hw_fire = src0_fire || src1_fire;
  wire sw_flag_wr = sfr_wr && hit_break;
  wire sw_trigger = sw_flag_wr && sfr_wdata[PDAB_BIT_BREAK_FLAG];
  wire break_fire = hw_fire || sw_trigger;

  // Flag: a hardware event in the clearing cycle wins over the clear
  wire flag_d = break_fire ? 1'b1 : (sw_flag_wr ? 1'b0 : break_flag_q);

  // Cycle-by-cycle block releases only at a cycle start with no event
  wire cbc_d = break_fire ? 1'b1 : (pwm_cycle_start ? 1'b0 : cbc_block_q);
  wire blocked = break_mode_select ? cbc_block_q : break_flag_q;

  // ==========================================================================
  // Dead-time prescaler: tick when the selected low bits are all ones
  wire [2:0] presc_mask = 3'((4'h1 << dt_prescale) - 4'h1);
  wire dt_tick = (presc_q & presc_mask) == presc_mask;

  // Period extension of 2P system clocks, P = count shifted by prescale
  // Widen before the shift, 2*63 shifted by 3 needs all ten bits
  wire [PDAB_HOLD_W-1:0] two_p_base = PDAB_HOLD_W'({dt_count, 1'b0});
  wire [PDAB_HOLD_W-1:0] two_p = two_p_base << dt_prescale;
  wire hold_load = extend_period && dt_on && pwm_cycle_start;

  // Update clock source for the FIFO duty chain
  logic fifo_src;
  always_comb begin
    unique case (pdab_fifo_sel_t'(fifo_sel_q))
      PDAB_FU_T0: fifo_src = timer0_overflow;
      PDAB_FU_T1: fifo_src = timer1_overflow;
      PDAB_FU_T3: fifo_src = timer3_overflow;
      PDAB_FU_S0: fifo_src = serial0_timer_overflow;
    endcase
  end

  // ==========================================================================
  // Register writes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fifo_sel_q <= 2'h0;
      dead_time_q <= PDAB_RST_REG;
      pwm_ctrl_q <= PDAB_RST_REG;
    end else if (sfr_wr) begin
      if (hit_fifo) begin
        fifo_sel_q <= sfr_wdata[PDAB_LSB_FIFO_SEL +: 2];
      end
      if (hit_dt) begin
        dead_time_q <= sfr_wdata;
      end
      if (hit_ctrl) begin
        pwm_ctrl_q <= sfr_wdata;
      end
    end
  end

  // Per-module mode registers
  always_ff @(posedge clk) begin
    for (int i = 0; i < NUM_CH; i++) begin
      if (!rst_n) begin
        mode_q[i] <= PDAB_RST_REG;
      end else if (sfr_wr && hit_mode && mode_idx == 8'(i)) begin
        mode_q[i] <= sfr_wdata;
      end
    end
  end

  // ==========================================================================
  // Break state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      break_flag_q <= 1'b0;
      cbc_block_q <= 1'b0;
    end else begin
      break_flag_q <= flag_d;
      cbc_block_q <= cbc_d;
    end
  end

  // Prescaler, alignment direction, extension hold, update pulse
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      presc_q <= 3'h0;
      dir_q <= 1'b0;
      hold_q <= '0;
      fifo_clk_q <= 1'b0;
    end else begin
      presc_q <= presc_q + 3'h1;
      // Direction flips each cycle start so one up-down sweep spans two cycles
      dir_q <= center_align_enable && (dir_q ^ pwm_cycle_start);
      if (hold_load) begin
        hold_q <= two_p;
      end else if (hold_q != '0) begin
        hold_q <= hold_q - 1'b1;
      end
      fifo_clk_q <= fifo_src;
    end
  end

  // ==========================================================================
  // Channels: even modules may drive a dead-timed complementary pair
  genvar p;
  generate
    for (p = 0; p < NUM_CH / 2; p++) begin : g_pair
      wire ev_en = mode_q[2*p][PDAB_BIT_CMP_EN] && mode_q[2*p][PDAB_BIT_PWM_EN];
      wire od_en = mode_q[2*p+1][PDAB_BIT_CMP_EN] && mode_q[2*p+1][PDAB_BIT_PWM_EN];
      wire dt_act = mode_q[2*p][PDAB_BIT_DT_EN] && pair_buffer_enable[p] && dt_on;
      logic hi;
      logic lo;
      pdab_dead_time #(.DT_W(6)) u_dt (
        .clk(clk),
        .rst_n(rst_n),
        .dt_tick(dt_tick),
        .dt_count(dt_count),
        .dt_active(dt_act),
        .pwm_in(pwm_raw[2*p]),
        .out_high(hi),
        .out_low(lo)
      );
      // Odd module follows the low side only while dead time owns the pair
      assign complementary_high[2*p] = hi;
      assign complementary_low[2*p] = lo;
      assign complementary_high[2*p+1] = dt_act ? lo : pwm_raw[2*p+1];
      assign complementary_low[2*p+1] = dt_act ? hi : ~pwm_raw[2*p+1];
      assign channel_pin_pwm_sel[2*p] = ev_en && !blocked;
      assign channel_pin_pwm_sel[2*p+1] = od_en && !blocked;
    end
  endgenerate

  // ==========================================================================
  // Read mux, registered; unmapped addresses read zero
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (hit_break) begin
      rd_mux[PDAB_BIT_BREAK_FLAG] = break_flag_q;
    end else if (hit_fifo) begin
      rd_mux[PDAB_LSB_FIFO_SEL +: 2] = fifo_sel_q;
    end else if (hit_dt) begin
      rd_mux = dead_time_q;
    end else if (hit_ctrl) begin
      rd_mux = pwm_ctrl_q;
    end else if (hit_mode) begin
      rd_mux = mode_q[mode_idx[2:0]];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rd_mux;
    end
  end

  // ==========================================================================
  // Outputs
  assign sfr_rdata = rdata_q;
  assign fifo_update_clock = fifo_clk_q;
  assign count_down = dir_q;
  assign counter_hold = hold_q != '0;
  assign break_flag = break_flag_q;
endmodule

// ### testbench/pdab_checker.sv
// Purpose: Port-level checks for the dead-time, alignment and break stage.
// Assumes: Register reads answer one cycle after the address is presented.
// Notes: Sees only top-level ports, so mode-dependent rules stay in the bench.
`timescale 1ns/1ps
module pdab_checker #(
  parameter int NUM_CH = 6
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  // Counter and update sources
  input wire logic pwm_cycle_start,
  input wire logic timer0_overflow,
  input wire logic timer1_overflow,
  input wire logic timer3_overflow,
  input wire logic serial0_timer_overflow,
  // Block outputs
  input wire logic [NUM_CH-1:0] complementary_high,
  input wire logic [NUM_CH-1:0] complementary_low,
  input wire logic [NUM_CH-1:0] channel_pin_pwm_sel,
  input wire logic fifo_update_clock,
  input wire logic count_down,
  input wire logic counter_hold,
  input wire logic break_flag
);
  // ==========================================================================
  // Helper: length of the current hold run, longest legal is 2*63*8
  logic [10:0] hold_len_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hold_len_q <= 11'h000;
    end else begin
      hold_len_q <= counter_hold ? hold_len_q + 11'h001 : 11'h000;
    end
  end

  // ==========================================================================
  // Properties
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_sw_trigger;
    sfr_wr && sfr_addr == 8'ha1 && sfr_wdata[4] |=> break_flag;
  endproperty
  a_sw_trigger: assert property (p_sw_trigger) else $error("flag not set by write");
  property p_block_pins;
    $rose(break_flag) |-> channel_pin_pwm_sel == '0;
  endproperty
  a_block_pins: assert property (p_block_pins) else $error("pins not blocked");
  property p_sw_clear_only;
    $fell(break_flag) |-> $past(sfr_wr && sfr_addr == 8'ha1 && !sfr_wdata[4]);
  endproperty
  a_sw_clear_only: assert property (p_sw_clear_only) else $error("flag cleared by hw");
  property p_no_overlap;
    (complementary_high & complementary_low) == '0;
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("both pair outputs high");
  property p_fifo_cause;
    fifo_update_clock |->
      $past(timer0_overflow | timer1_overflow | timer3_overflow | serial0_timer_overflow);
  endproperty
  a_fifo_cause: assert property (p_fifo_cause) else $error("update clock without source");
  property p_dir_at_start;
    $rose(count_down) |-> $past(pwm_cycle_start);
  endproperty
  a_dir_at_start: assert property (p_dir_at_start) else $error("direction off cycle start");
  property p_hold_bound;
    hold_len_q <= 11'd1008;
  endproperty
  a_hold_bound: assert property (p_hold_bound) else $error("period extension too long");
  property p_unmapped_zero;
    !(sfr_addr inside {8'ha1, 8'ha4, 8'hbc, [8'hda:8'hdf]}) |=> sfr_rdata == 8'h00;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not 0");
endmodule

// ### testbench/pdab_power_stage.sv
// Purpose: Power stage legs and over-current comparator on the pin side.
// Assumes: A leg conducts its high or low switch only while its pin is PWM.
// Notes: Comparator answers one cycle late, like a filtered analog trip.
`timescale 1ns/1ps
module pdab_power_stage (
  // Clock
  input wire logic clk,
  // Gate drive from the block
  input wire logic [5:0] gate_high,
  input wire logic [5:0] gate_low,
  input wire logic [5:0] gate_sel,
  // Fault injection from the bench
  input wire logic trip,
  // Back to the block and the bench
  output logic over_current,
  output logic shoot_through
);
  // ==========================================================================
  // Sticky short detect, a shorted leg would destroy the real switches
  initial shoot_through = 1'b0;
  initial over_current = 1'b0;
  always @(posedge clk) begin
    shoot_through <= shoot_through | (|(gate_high & gate_low & gate_sel));
    over_current <= trip;
  end
endmodule

// ### testbench/tb_top.sv
// Purpose: Self-checking bench for the dead-time, alignment and break stage.
// Assumes: Dead-time delay depends on the free prescaler phase, so a window.
// Notes: Break source 0 external interrupt comes from the power stage model.
`timescale 1ns/1ps
module tb_top;
  import pdab_pkg::*;
  // ==========================================================================
  // Stimulus and observation
  logic clk = 0, rst_n = 0, wr = 0, cs = 0, ps_oc, ps_short, fclk, dn, hold, flag;
  logic [7:0] addr = 0, wdata = 0, rdata;
  logic [3:0] page = 0, evt = 0, ovf = 0;
  logic [5:0] raw = 0, hi, lo, sel;
  logic [2:0] pbe = 0;
  logic [1:0] res = 0;
  int bad_count = 0, tests_run = 0, k, n, p, d;
  always #2.5 clk = ~clk;
  pdab_top dut (.clk, .rst_n, .sfr_addr(addr), .sfr_page(page), .sfr_wr(wr),
    .sfr_wdata(wdata), .sfr_rdata(rdata), .pwm_raw(raw), .pwm_cycle_start(cs),
    .pair_buffer_enable(pbe), .counter_resolution(res), .ext_irq1_event(ps_oc),
    .ext_irq2_event(evt[1]), .timer2_external_input(evt[2]),
    .keyboard_match_event(evt[3]), .timer0_overflow(ovf[0]), .timer1_overflow(ovf[1]),
    .timer3_overflow(ovf[2]), .serial0_timer_overflow(ovf[3]), .complementary_high(hi),
    .complementary_low(lo), .channel_pin_pwm_sel(sel), .fifo_update_clock(fclk),
    .count_down(dn), .counter_hold(hold), .break_flag(flag));
  pdab_power_stage stage (.clk, .gate_high(hi), .gate_low(lo), .gate_sel(sel),
    .trip(evt[0]), .over_current(ps_oc), .shoot_through(ps_short));
  // ==========================================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wrr(input logic [7:0] a, input logic [3:0] pg, input logic [7:0] v);
    @(posedge clk) {addr, page, wdata, wr} <= {a, pg, v, 1'b1};
    @(posedge clk) wr <= 1'b0;
    #1;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [3:0] pg, input logic [7:0] e);
    @(posedge clk) {addr, page} <= {a, pg};
    @(posedge clk);
    #1 chk("rdata", e, rdata);
  endtask
  task automatic pulse_ev(input int e);
    @(posedge clk) evt <= 4'h1 << e;
    @(posedge clk) evt <= 4'h0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic pulse_cs();
    @(posedge clk) cs <= 1'b1;
    @(posedge clk) cs <= 1'b0;
    #1;
  endtask
  // Which source code pair reacts to event e (0 irq1, 1 irq2, 2 t2 input, 3 keys)
  function automatic logic brk_exp(input logic [4:0] c, input int e);
    return (c[2:0] == 3'b010 && e == 0) || (c[2:0] == 3'b011 && e == 2) ||
      (c[2:0] == 3'b100 && e == 3) || (c[4:3] == 2'b01 && e == 1) ||
      (c[4:3] == 2'b11 && e == 3);
  endfunction
  // Measure edge-to-rise delay of the even high side of pair 0
  task automatic dt_run(input int pp, input int nn, input logic b, input int l, input int h);
    wrr(8'hbc, 4'h1, {pp[1:0], nn[5:0]});
    @(posedge clk) pbe <= {2'b00, b};
    repeat (520) @(posedge clk);
    #1 chk("pair_low", 1, lo[0]);
    @(posedge clk) raw <= {5'($urandom), 1'b1};
    k = 0;
    do begin
      @(posedge clk);
      #1 k++;
    end while (hi[0] !== 1'b1 && k < 600);
    chk("dt_delay", 1, k >= l && k <= h);
    chk("pair_low", 0, lo[0]);
    @(posedge clk) raw <= 6'h00;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #250000;
    bad_count++;
    give_verdict();
  end
  // ==========================================================================
  // Main sequence
  initial begin
    k = $urandom(64983);
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    res <= 2'($urandom);
    rdc(8'ha1, 4'h0, 8'h00);
    rdc(8'ha4, 4'h6, 8'h00);
    rdc(8'hbc, 4'h1, 8'h00);
    rdc(8'hbc, 4'h0, 8'h00);
    rdc(8'hda, 4'h0, 8'h00);
    k = $urandom;
    wrr(8'hbc, 4'h1, k[7:0]);
    rdc(8'hbc, 4'h1, k[7:0]);
    wrr(8'ha4, 4'h6, k[15:8]);
    rdc(8'ha4, 4'h6, k[15:8] & 8'h0c);
    wrr(8'hdd, 4'h3, k[23:16]);
    rdc(8'hdd, 4'h3, k[23:16]);
    rdc(8'hda, 4'h2, 8'h00);
    wrr(8'ha2, 4'h0, 8'hff);
    rdc(8'ha2, 4'h0, 8'h00);
    wrr(8'hdd, 4'h3, 8'h00);
    // Update clock source for every select code
    for (int c = 0; c < 4; c++) begin
      wrr(8'ha4, 4'h6, 8'(c << 2));
      for (int s = 0; s < 4; s++) begin
        @(posedge clk) ovf <= 4'h1 << s;
        @(posedge clk) ovf <= 4'h0;
        #1 chk("fifo_clk", s == c, fclk);
      end
    end
    // Every break source code against every event, latched mode
    for (int c = 0; c < 32; c++) begin
      wrr(8'hbc, 4'h0, 8'(c));
      for (int e = 0; e < 4; e++) begin
        pulse_ev(e);
        chk("break_flag", brk_exp(5'(c), e), flag);
        wrr(8'ha1, 4'h0, 8'h00);
      end
    end
    // Cycle-by-cycle break releases pins, flag stays
    wrr(8'hda, 4'h0, 8'h42);
    wrr(8'hbc, 4'h0, 8'h22);
    // Cycle block left over from the source sweep clears only at a cycle start
    pulse_cs();
    chk("sel0", 1, sel[0]);
    pulse_ev(0);
    chk("sel0", 0, sel[0]);
    pulse_cs();
    chk("sel0", 1, sel[0]);
    chk("break_flag", 1, flag);
    // Latched break holds through cycle start until cleared
    wrr(8'hbc, 4'h0, 8'h02);
    wrr(8'ha1, 4'h0, 8'h00);
    pulse_ev(0);
    pulse_cs();
    chk("sel0", 0, sel[0]);
    wrr(8'ha1, 4'h0, 8'h00);
    chk("sel0", 1, sel[0]);
    wrr(8'ha1, 4'h0, 8'h10);
    chk("break_flag", 1, flag);
    wrr(8'ha1, 4'h0, 8'h00);
    // Dead time per prescale, then refused without buffering or with zero count
    wrr(8'hda, 4'h0, 8'hc2);
    for (p = 0; p < 4; p++) begin
      n = 1 + $urandom_range(0, 5);
      d = 1 << p;
      dt_run(p, n, 1'b1, (n - 1) * d + 2, n * d + 3);
    end
    dt_run(0, 5, 1'b0, 1, 2);
    dt_run(3, 0, 1'b1, 1, 2);
    // Period extension of twice the dead time
    p = $urandom_range(0, 3);
    n = $urandom_range(1, 63);
    wrr(8'hbc, 4'h1, {p[1:0], n[5:0]});
    wrr(8'hbc, 4'h0, 8'h40);
    pulse_cs();
    k = 0;
    while (hold === 1'b1 && k < 1100) begin
      @(posedge clk);
      #1 k++;
    end
    chk("hold_len", (2 * n) << p, k);
    // Centre alignment toggles direction each cycle start
    wrr(8'hbc, 4'h0, 8'h80);
    pulse_cs();
    chk("count_down", 1, dn);
    pulse_cs();
    chk("count_down", 0, dn);
    chk("short", 0, ps_short);
    give_verdict();
  end
endmodule

// Checker sees only the top-level ports of the block
bind pdab_top pdab_checker #(.NUM_CH(NUM_CH)) chk_i (.clk, .rst_n, .sfr_addr, .sfr_wr,
  .sfr_wdata, .sfr_rdata, .pwm_cycle_start, .timer0_overflow, .timer1_overflow,
  .timer3_overflow, .serial0_timer_overflow, .complementary_high, .complementary_low,
  .channel_pin_pwm_sel, .fifo_update_clock, .count_down, .counter_hold, .break_flag);
